// ==== parallel_output_link_config_test.sv ====
// self-checking bench: apb host driving the output device over the link
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module parallel_output_link_config_test;
  import pol_pkg::*;
  typedef struct {logic k; logic [32:0] e; logic [32:0] m; logic [11:0] w;} pol_note_t;
  localparam logic [32:0] MW = 33'h1FFFF0002;
  localparam logic [32:0] MS = 33'h100000002;
  localparam logic [32:0] MF = 33'h1FFFFFFFF;
  localparam int          LIMIT = 60000;
  logic        i_clk = 1'b0, i_rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h00000026;
  logic        smp_valid = 1'b0, smp_ready, tref = 1'b0;
  logic [23:0] smp_data = 24'h0;
  int          failures = 0, comparisons = 0, cycles = 0;
  pol_note_t   notes[$];
  pol_note_t   nt;
  logic [32:0] x, e;
  pol_if pol_if_inst ();
  pol_dev pol_dev_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(pol_if_inst),
    .i_smp_valid(smp_valid), .i_smp_data(smp_data), .o_smp_ready(smp_ready),
    .i_tref(tref), .o_link_on());
  pol_host pol_host_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(pol_if_inst));
  pol_sva pol_sva_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .cfg_req(pol_if_inst.cfg_req),
    .cfg_we(pol_if_inst.cfg_we), .cfg_addr(pol_if_inst.cfg_addr),
    .cfg_wdata(pol_if_inst.cfg_wdata), .cfg_ack(pol_if_inst.cfg_ack),
    .lclk(pol_if_inst.lclk), .bus(pol_if_inst.bus), .strobe(pol_if_inst.strobe),
    .pwr(pol_if_inst.pwr));
  always #2.5 i_clk = ~i_clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [32:0] rv(input logic [15:0] v);
    return {1'b0, v, 16'h0};
  endfunction : rv
  task automatic results();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // one apb transfer; reads leave a note for the monitor
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic k, input logic [32:0] en, input logic [32:0] m,
                     input logic [11:0] wm, output logic [31:0] r);
    if (!w) notes.push_back('{k, en, m, wm});
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask : acc
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(1'b1, a, d, 1'b0, 33'h0, 33'h0, 12'h0, r);
  endtask : wr
  // device access via host, then status holding refusal and read data
  task automatic cfg(input logic w, input logic [9:0] a, input logic [15:0] d,
                     input logic [32:0] en, input logic [32:0] m);
    logic [31:0] r;
    wr(H_ADDR, {22'h0, a});
    wr(H_WDATA, {16'h0, d});
    wr(H_GO, {31'h0, w});
    r = 32'h1;
    while (r[0]) acc(1'b0, H_STAT, 32'h0, 1'b0, 33'h0, 33'h100000000, 12'h0, r);
    acc(1'b0, H_STAT, 32'h0, 1'b0, en, m, 12'h0, r);
  endtask : cfg
  // lane notes are judged against the pattern bit seen on bit 7 of each bus
  always @(posedge i_clk) begin
    if (psel && penable && pready && !pwrite) begin
      nt = notes.pop_front();
      x  = {pslverr, prdata};
      e  = nt.k ? (({9'h0, {12{x[19]}}, {12{x[7]}}} & {9'h0, nt.w, nt.w}) ^ nt.e) : nt.e;
      `CHK(x & nt.m, e)
    end
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      results();
    end
  end
  initial begin
    logic [7:0]  p, md;
    logic [11:0] v, wm, m0, m1, m2, m3;
    logic [31:0] r;
    int          n;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    cfg(1'b0, ADR_PCTL, 16'h0, rv({8'h0, PCTL_RST}), MW);
    cfg(1'b0, ADR_LEN, 16'h0, rv({8'h0, LEN_RST}), MW);
    cfg(1'b0, ADR_OUTPUT_LINK_MODE, 16'h0, rv({8'h0, OUTPUT_LINK_MODE_RST}), MW);
    cfg(1'b0, 10'h3FF, 16'h0, rv(16'h0), MW);
    acc(1'b0, 12'h020, 32'h0, 1'b0, 33'h100000000, 33'h100000000, 12'h0, r);
    cfg(1'b1, ADR_OUTPUT_LINK_MODE, 16'h5, 33'h2, MS);
    cfg(1'b1, ADR_CAL, 16'h0, 33'h2, MS);
    cfg(1'b1, ADR_LEN, 16'h0, 33'h0, MS);
    acc(1'b0, H_STAT, 32'h0, 1'b0, 33'h0, 33'h100000004, 12'h0, r);
    cfg(1'b1, ADR_LEN, 16'h1, 33'h2, MS);
    tref <= 1'b1;
    repeat (2) @(posedge i_clk);
    tref <= 1'b0;
    // link off: the buffer must fill and then hold back
    smp_valid <= 1'b1;
    n = 0;
    repeat (20) begin
      r = xs();
      smp_data <= r[23:0];
      @(negedge i_clk);
      if (smp_ready === 1'b1) n++;
      @(posedge i_clk);
    end
    smp_valid <= 1'b0;
    `CHK(n, FIFO_DEPTH)
    cfg(1'b1, ADR_CAL, 16'h1, 33'h0, MS);
    cfg(1'b1, ADR_LEN, 16'h1, 33'h0, MS);
    repeat (400) @(posedge i_clk);
    `CHK(smp_ready, 1'b1)
    acc(1'b0, H_CAP0, 32'h0, 1'b0, 33'h0, MF, 12'h0, r);
    // every width, interleave, alignment and demux code; last pass uses sample regs
    for (int k = 0; k < 4; k++) begin
      r  = xs();
      p  = {r[7:5], k != 3, r[3:0]};
      md = {r[15:14], 2'(k), r[11], k[0], k[1], k != 2};
      v  = r[27:16];
      wm = WID_MASK[k];
      m0 = {3'h0, p[0], 8'h00};
      m1 = {2'h0, p[1], 9'h000};
      m2 = {1'h0, p[2], 10'h000};
      m3 = {p[3], 11'h000};
      cfg(1'b1, ADR_LEN, 16'h0, 33'h0, MS);
      cfg(1'b1, ADR_CAL, 16'h0, 33'h0, MS);
      cfg(1'b1, ADR_OUTPUT_LINK_MODE, {8'h0, md}, 33'h0, MS);
      cfg(1'b1, ADR_PCTL, {8'h0, p}, 33'h0, MS);
      for (int i = 0; i < NPAT; i++) cfg(1'b1, ADR_PAT0 + 10'(2 * i), {r[31:28], v}, 33'h0, MS);
      cfg(1'b1, ADR_PSEL, 16'h1, 33'h0, MS);
      cfg(1'b1, ADR_CAL, 16'h1, 33'h0, MS);
      cfg(1'b1, ADR_LEN, 16'h1, 33'h0, MS);
      cfg(1'b0, ADR_PCTL, 16'h0, rv({8'h0, p}), MW);
      cfg(1'b0, ADR_PAT0 + 10'h2, 16'h0, rv({r[31:28], v}), MW);
      repeat (200) @(posedge i_clk);
      if (p[PCTL_LANE]) begin
        acc(1'b0, H_CAP0, 32'h0, 1'b1, {9'h0, m1, m0}, MF, wm, r);
        if (md[0]) acc(1'b0, H_CAP1, 32'h0, 1'b1, {9'h0, m3, m2}, MF, wm, r);
      end else begin
        acc(1'b0, H_CAP0, 32'h0, 1'b0, {9'h0, (v ^ m1) & wm, (v ^ m0) & wm}, MF, wm, r);
        acc(1'b0, H_CAP1, 32'h0, 1'b0, {9'h0, (v ^ m3) & wm, (v ^ m2) & wm}, MF, wm, r);
      end
    end
    results();
  end
endmodule : parallel_output_link_config_test

// ==== pol_dev.sv ====
// output device end: config registers, sample fifo, pattern and bus drive
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module pol_fifo #(
  parameter int W = 24,
  parameter int D = 8
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_valid,
  input  wire logic [W-1:0]  i_data,
  output      logic          o_ready,
  output      logic          o_valid,
  output      logic [W-1:0]  o_data,
  input  wire logic          i_ready
);
  // depth must be a power of two: pointers wrap naturally
  localparam int PW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [PW-1:0] wp_q, rp_q;
  logic [PW:0]   cnt_q;
  logic [PW:0]   cnt_d;
  logic          rdy_q;
  wire push = i_valid & rdy_q;
  wire pop  = o_valid & i_ready;
  assign cnt_d   = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
  assign o_valid = (cnt_q != '0);
  assign o_data  = mem[rp_q];
  assign o_ready = rdy_q;
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_q] <= i_data;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      wp_q  <= wp_q + PW'(push);
      rp_q  <= rp_q + PW'(pop);
      cnt_q <= cnt_d;
      rdy_q <= cnt_d < (PW+1)'(D);
    end
  end
endmodule : pol_fifo

// Functional notes
// RULE1: lane shortcut replaces samples with fixed sequence
// RULE2: host still selects user pattern source
// RULE3: bus inversion applies to lane shortcut too
// RULE4: invert bit 11/10/9/8 on bus D/C/B/A
// RULE5: host changes pattern control only while disabled
// RULE6: link enable bit, resets to one
// RULE7: disabled link: reset, powered down, clock gated
// RULE8: disabled link holds frame counter in reset
// RULE9: host clears enable before other config writes
// RULE10: calibration on before enable, off after
// RULE11: calibration off while changing interleave bit
// RULE12: width field selects 12/11/10/8 bit samples
// RULE13: interleave bit: dual or single channel
// RULE14: alignment bit: staggered or aligned buses
// RULE15: demux bit: two or four buses
// RULE16: unit interval one or two link cycles
// RULE17: eight 12-bit pattern sample registers
// RULE18: reserved bits stored, read back, no effect
module pol_dev (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  pol_if.dev                              link,
  input  wire logic                       i_smp_valid,
  input  wire logic [2*pol_pkg::SW-1:0]   i_smp_data,
  output      logic                       o_smp_ready,
  input  wire logic                       i_tref,
  output      logic                       o_link_on
);
  import pol_pkg::*;
  localparam int CB = 1 + AW + DW;

  // config handshake crossing
  logic          req_s1_q, req_s2_q, rq_q, ack_q;
  logic [CB-1:0] cb_s1_q, cb_s2_q;
  logic [DW-1:0] rdata_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      rq_q     <= 1'b0;
      ack_q    <= 1'b0;
      cb_s1_q  <= '0;
      cb_s2_q  <= '0;
    end else begin
      req_s1_q <= link.cfg_req;
      req_s2_q <= req_s1_q;
      rq_q     <= req_s2_q;
      ack_q    <= rq_q;
      cb_s1_q  <= {link.cfg_we, link.cfg_addr, link.cfg_wdata};
      cb_s2_q  <= cb_s1_q;
    end
  end
  wire          c_we    = cb_s2_q[CB-1];
  wire [AW-1:0] c_addr  = cb_s2_q[DW +: AW];
  wire [DW-1:0] c_wdata = cb_s2_q[DW-1:0];
  wire          wr_stb  = req_s2_q & ~rq_q & c_we;

  // register file
  logic [7:0]    pctl_q, len_q, mode_q, psel_q, cal_q;
  logic [DW-1:0] pat_q [NPAT];
  wire           pat_hit = (c_addr & PAT_AMASK) == ADR_PAT0;
  wire [2:0]     pattern_source_select = c_addr[PAT_IDX_LSB +: 3];
  wire           wr_pctl = wr_stb & (c_addr == ADR_PCTL);
  wire           wr_len  = wr_stb & (c_addr == ADR_LEN);
  wire           wr_mode = wr_stb & (c_addr == ADR_OUTPUT_LINK_MODE);
  wire           wr_psel = wr_stb & (c_addr == ADR_PSEL);
  wire           wr_cal  = wr_stb & (c_addr == ADR_CAL);
  // RULE18: full bytes kept for read back
  wire [DW-1:0]  rd_val  = pat_hit ? pat_q[pattern_source_select] :
                           (c_addr == ADR_PCTL)  ? {8'h00, pctl_q} :
                           (c_addr == ADR_LEN)   ? {8'h00, len_q}  :
                           (c_addr == ADR_OUTPUT_LINK_MODE) ? {8'h00, mode_q} :
                           (c_addr == ADR_PSEL)  ? {8'h00, psel_q} :
                           (c_addr == ADR_CAL)   ? {8'h00, cal_q}  : 16'h0000;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pctl_q  <= PCTL_RST;
      // RULE6: enabled out of reset
      len_q   <= LEN_RST;
      mode_q  <= OUTPUT_LINK_MODE_RST;
      psel_q  <= PSEL_RST;
      cal_q   <= CAL_RST;
      rdata_q <= '0;
    end else begin
      if (wr_pctl) pctl_q <= c_wdata[7:0];
      if (wr_len)  len_q  <= c_wdata[7:0];
      if (wr_mode) mode_q <= c_wdata[7:0];
      if (wr_psel) psel_q <= c_wdata[7:0];
      if (wr_cal)  cal_q  <= c_wdata[7:0];
      if (req_s2_q) rdata_q <= rd_val;
    end
  end
  // RULE17: pattern sample storage
  for (genvar i = 0; i < NPAT; i++) begin : g_pat
    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        pat_q[i] <= (i % 2 == 1) ? PAT_RST_ODD : PAT_RST_EVEN;
      end else if (wr_stb & pat_hit & (pattern_source_select == 3'(i))) begin
        pat_q[i] <= c_wdata;
      end
    end
  end
  assign link.cfg_ack   = ack_q;
  assign link.cfg_rdata = rdata_q;

  wire       en      = len_q[LEN_EN];
  wire       lane    = pctl_q[PCTL_LANE];
  wire       demux   = mode_q[MODE_DEMUX];
  wire       aligned = mode_q[MODE_ALIGN];
  wire       des     = mode_q[MODE_DES];
  wire [1:0] wid     = mode_q[MODE_WID +: 2];
  wire       usr     = psel_q[PSEL_USR];

  // link clock divider, gated low while disabled
  logic [DCW-1:0] dcnt_q;
  logic           lclk_q, phase_q, fall_q, pwr_q;
  wire  wrap  = dcnt_q == DCW'(LCLK_HALF - 1);
  wire  fall  = en & wrap & lclk_q;
  // RULE16: second link cycle of a demux-by-2 unit interval
  wire  half  = demux & phase_q;
  wire  ui_st = fall & ~half;
  always_ff @(posedge i_clk) begin
    // RULE7: interface held in reset, clock gated
    if (!i_rst_n || !en) begin
      dcnt_q  <= '0;
      lclk_q  <= 1'b0;
      phase_q <= 1'b0;
      fall_q  <= 1'b0;
    end else begin
      dcnt_q  <= wrap ? '0 : dcnt_q + DCW'(1);
      lclk_q  <= wrap ? ~lclk_q : lclk_q;
      phase_q <= (fall & demux) ? ~phase_q : phase_q;
      fall_q  <= fall;
    end
  end

  // sample stream; disabled link stops draining so the fifo back-pressures
  logic          f_valid;
  logic [2*SW-1:0] f_data;
  pol_fifo #(.W(2*SW), .D(FIFO_DEPTH)) u_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_valid (i_smp_valid),
    .i_data  (i_smp_data),
    .o_ready (o_smp_ready),
    .o_valid (f_valid),
    .o_data  (f_data),
    .i_ready (fall & ~usr)
  );

  // user pattern source
  logic [2:0]    pidx_q;
  logic [SW-1:0] pv [NPAT];
  for (genvar i = 0; i < NPAT; i++) begin : g_pv
    // RULE1: fixed lane sequence overrides the samples
    assign pv[i] = lane ? {SW{LANE_SEQ[i]}} : pat_q[i][SW-1:0];
  end
  // RULE13: single channel spreads consecutive samples, dual repeats
  wire [2:0]    pidx_b = des ? pidx_q + PIDX_ONE : pidx_q;
  wire [SW-1:0] lo = usr ? pv[pidx_q] : (f_valid ? f_data[SW-1:0] : '0);
  wire [SW-1:0] hi = usr ? pv[pidx_b] : (f_valid ? f_data[2*SW-1:SW] : '0);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !en) begin
      pidx_q <= '0;
    end else if (fall & usr) begin
      pidx_q <= pidx_q + (des ? PIDX_TWO : PIDX_ONE);
    end
  end

  // bus drive; staggering puts odd buses one clock behind
  logic [SW-1:0] bus_q [NBUS];
  logic [SW-1:0] nv_q  [NBUS];
  logic [NBUS-1:0] ld_q;
  for (genvar b = 0; b < NBUS; b++) begin : g_bus
    wire [SW-1:0] src  = (b % 2 == 1) ? hi : lo;
    // RULE3: inversion also under the lane shortcut
    wire          inv  = usr & pctl_q[b];
    // RULE4: bus b flips pattern bit 8+b
    wire [SW-1:0] flip = {{(SW-1){1'b0}}, inv} << (INV_BASE + b);
    // RULE12: low bits cleared for narrower samples
    wire [SW-1:0] nv   = (src ^ flip) & WID_MASK[wid];
    // RULE15: buses C and D only carry data in demux-by-2
    wire          act  = fall & ((b < 2) ? ~half : half);
    // RULE14: even buses lead when staggered
    wire          now  = act & ~aligned & (b % 2 == 0);
    wire          late = ld_q[b] & (aligned | (b % 2 == 1));
    always_ff @(posedge i_clk) begin
      if (!i_rst_n || !en) begin
        bus_q[b] <= '0;
        nv_q[b]  <= '0;
        ld_q[b]  <= 1'b0;
      end else begin
        ld_q[b] <= act;
        if (act) nv_q[b] <= nv;
        if (now) bus_q[b] <= nv;
        else if (late) bus_q[b] <= nv_q[b];
      end
    end
    assign link.bus[b] = bus_q[b];
  end

  // frame counter and strobe
  logic       t1_q, t2_q, t3_q, strobe_q;
  logic [7:0] fcnt_q;
  wire        tref_edge = t2_q & ~t3_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      t1_q <= 1'b0;
      t2_q <= 1'b0;
      t3_q <= 1'b0;
    end else begin
      t1_q <= i_tref;
      t2_q <= t1_q;
      t3_q <= t2_q;
    end
  end
  always_ff @(posedge i_clk) begin
    // RULE8: no realignment while disabled
    if (!i_rst_n || !en) begin
      fcnt_q   <= '0;
      strobe_q <= 1'b0;
    end else if (tref_edge) begin
      fcnt_q   <= '0;
    end else if (ui_st) begin
      fcnt_q   <= (fcnt_q == FRAME_LAST) ? '0 : fcnt_q + 8'h01;
      strobe_q <= (fcnt_q == 8'h00);
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pwr_q <= 1'b0;
    end else begin
      // RULE7: outputs powered only when enabled
      pwr_q <= en;
    end
  end
  assign link.lclk   = lclk_q;
  assign link.strobe = strobe_q;
  assign link.pwr    = pwr_q;
  assign o_link_on   = pwr_q;
endmodule : pol_dev

// ==== pol_host.sv ====
// host end: apb command registers, config handshake, bus capture
`timescale 1ns/1ps
module pol_host (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_psel,
  input  wire logic         i_penable,
  input  wire logic         i_pwrite,
  input  wire logic [11:0]  i_paddr,
  input  wire logic [31:0]  i_pwdata,
  output      logic [31:0]  o_prdata,
  output      logic         o_pready,
  output      logic         o_pslverr,
  pol_if.host               link
);
  import pol_pkg::*;
  localparam int RX = 3 + NBUS * SW;

  // crossings from the device
  logic          ack_s1_q, ack_s2_q;
  logic [DW-1:0] rd_s1_q, rd_s2_q;
  logic [RX-1:0] rx_s1_q, rx_s2_q;
  logic          lclk_s3_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ack_s1_q  <= 1'b0;
      ack_s2_q  <= 1'b0;
      rd_s1_q   <= '0;
      rd_s2_q   <= '0;
      rx_s1_q   <= '0;
      rx_s2_q   <= '0;
      lclk_s3_q <= 1'b0;
    end else begin
      ack_s1_q  <= link.cfg_ack;
      ack_s2_q  <= ack_s1_q;
      rd_s1_q   <= link.cfg_rdata;
      rd_s2_q   <= rd_s1_q;
      rx_s1_q   <= {link.lclk, link.strobe, link.pwr, link.bus};
      rx_s2_q   <= rx_s1_q;
      lclk_s3_q <= rx_s2_q[RX-1];
    end
  end
  wire lclk_rise = rx_s2_q[RX-1] & ~lclk_s3_q;
  wire rx_strobe = rx_s2_q[RX-2];
  wire rx_pwr    = rx_s2_q[RX-3];

  // apb slave, answers on the second access cycle
  logic        pready_q, pslverr_q;
  logic [31:0] prdata_q;
  wire acc   = i_psel & i_penable;
  wire first = acc & ~pready_q;
  wire done  = acc & pready_q;
  wire wr    = done & i_pwrite;
  wire hit   = (i_paddr == H_ADDR) | (i_paddr == H_WDATA) | (i_paddr == H_GO) |
               (i_paddr == H_STAT) | (i_paddr == H_CAP0) | (i_paddr == H_CAP1) |
               (i_paddr == H_STRB);

  pol_hst_t            state_q;
  logic [AW-1:0]       haddr_q;
  logic [DW-1:0]       hwd_q, hrd_q, scnt_q;
  logic                req_q, we_q, refused_q, en_sh_q, cal_sh_q, des_sh_q;
  logic [2*SW-1:0]     cap0_q, cap1_q;
  wire busy = (state_q != HS_IDLE);
  wire [31:0] rd_val = (i_paddr == H_ADDR)  ? {22'h000000, haddr_q} :
                       (i_paddr == H_WDATA) ? {16'h0000, hwd_q} :
                       (i_paddr == H_STAT)  ? {hrd_q, 13'h0000, rx_pwr, refused_q, busy} :
                       (i_paddr == H_CAP0)  ? {8'h00, cap0_q} :
                       (i_paddr == H_CAP1)  ? {8'h00, cap1_q} :
                       (i_paddr == H_STRB)  ? {16'h0000, scnt_q} : 32'h00000000;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= first;
      pslverr_q <= first & ~hit;
      if (first) prdata_q <= rd_val;
    end
  end
  assign o_pready  = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_prdata  = prdata_q;

  // ordering checks on a device write
  wire gwe   = i_pwdata[GO_WR];
  wire go    = wr & (i_paddr == H_GO) & ~busy;
  // RULE5: RULE9: config other than the enable register only changes while the link is off
  wire v_off = en_sh_q & (haddr_q != ADR_LEN);
  // RULE10: calibration must enclose the enabled period
  wire v_cal = ((haddr_q == ADR_LEN) & hwd_q[LEN_EN] & ~cal_sh_q) |
               ((haddr_q == ADR_CAL) & ~hwd_q[CAL_EN] & en_sh_q);
  // RULE11: interleave bit frozen while calibrating
  wire v_des = (haddr_q == ADR_OUTPUT_LINK_MODE) & cal_sh_q & (hwd_q[MODE_DES] != des_sh_q);
  wire viol  = gwe & (v_off | v_cal | v_des);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q   <= HS_IDLE;
      haddr_q   <= '0;
      hwd_q     <= '0;
      hrd_q     <= '0;
      req_q     <= 1'b0;
      we_q      <= 1'b0;
      refused_q <= 1'b0;
      en_sh_q   <= LEN_RST[LEN_EN];
      cal_sh_q  <= CAL_RST[CAL_EN];
      des_sh_q  <= OUTPUT_LINK_MODE_RST[MODE_DES];
    end else begin
      if (wr & (i_paddr == H_ADDR) & ~busy) haddr_q <= i_pwdata[AW-1:0];
      if (wr & (i_paddr == H_WDATA) & ~busy) hwd_q <= i_pwdata[DW-1:0];
      unique case (state_q)
        HS_IDLE: begin
          if (go) begin
            refused_q <= viol;
            we_q      <= gwe;
            if (!viol) state_q <= HS_REQ;
          end
        end
        HS_REQ: begin
          req_q <= 1'b1;
          if (ack_s2_q) begin
            req_q   <= 1'b0;
            hrd_q   <= rd_s2_q;
            state_q <= HS_DROP;
            if (we_q && haddr_q == ADR_LEN) en_sh_q <= hwd_q[LEN_EN];
            if (we_q && haddr_q == ADR_CAL) cal_sh_q <= hwd_q[CAL_EN];
            if (we_q && haddr_q == ADR_OUTPUT_LINK_MODE) des_sh_q <= hwd_q[MODE_DES];
          end
        end
        HS_DROP: begin
          if (!ack_s2_q) state_q <= HS_IDLE;
        end
      endcase
    end
  end
  assign link.cfg_req   = req_q;
  assign link.cfg_we    = we_q;
  assign link.cfg_addr  = haddr_q;
  assign link.cfg_wdata = hwd_q;

  // capture on link clock rising edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cap0_q <= '0;
      cap1_q <= '0;
      scnt_q <= '0;
    end else if (lclk_rise & rx_pwr) begin
      cap0_q <= rx_s2_q[2*SW-1:0];
      cap1_q <= rx_s2_q[4*SW-1:2*SW];
      if (rx_strobe) scnt_q <= scnt_q + 16'h0001;
    end
  end
endmodule : pol_host

// ==== pol_if.sv ====
// link between the output device and its host / receiving logic
`timescale 1ns/1ps
interface pol_if;
  import pol_pkg::*;
  logic                      cfg_req;
  logic                      cfg_we;
  logic [AW-1:0]             cfg_addr;
  logic [DW-1:0]             cfg_wdata;
  logic                      cfg_ack;
  logic [DW-1:0]             cfg_rdata;
  logic                      lclk;
  logic [NBUS-1:0][SW-1:0]   bus;
  logic                      strobe;
  logic                      pwr;
  modport dev  (input cfg_req, cfg_we, cfg_addr, cfg_wdata,
                output cfg_ack, cfg_rdata, lclk, bus, strobe, pwr);
  modport host (output cfg_req, cfg_we, cfg_addr, cfg_wdata,
                input cfg_ack, cfg_rdata, lclk, bus, strobe, pwr);
endinterface : pol_if

// ==== pol_pkg.sv ====
// shared constants for the parallel output link configuration block
package pol_pkg;
  // timing
  localparam int CLK_PERIOD_NS  = 5;
  localparam int LCLK_PERIOD_NS = 80;
  localparam int LCLK_HALF      = LCLK_PERIOD_NS / CLK_PERIOD_NS / 2;
  localparam int DCW            = $clog2(LCLK_HALF);
  // widths
  localparam int AW   = 10;
  localparam int DW   = 16;
  localparam int SW   = 12;
  localparam int NBUS = 4;
  localparam int NPAT = 8;
  localparam int FIFO_DEPTH = 8;
  // device register map
  localparam logic [AW-1:0] ADR_PAT0  = 10'h180;
  localparam logic [AW-1:0] PAT_AMASK = 10'h3F1;
  localparam int            PAT_IDX_LSB = 1;
  localparam logic [AW-1:0] ADR_PCTL  = 10'h190;
  localparam logic [AW-1:0] ADR_LEN   = 10'h200;
  localparam logic [AW-1:0] ADR_OUTPUT_LINK_MODE = 10'h201;
  localparam logic [AW-1:0] ADR_PSEL  = 10'h1F0;
  localparam logic [AW-1:0] ADR_CAL   = 10'h060;
  // reset values
  localparam logic [7:0]    PCTL_RST  = 8'h1E;
  localparam logic [7:0]    LEN_RST   = 8'h01;
  localparam logic [7:0]    OUTPUT_LINK_MODE_RST = 8'h01;
  localparam logic [7:0]    PSEL_RST  = 8'h00;
  localparam logic [7:0]    CAL_RST   = 8'h00;
  localparam logic [DW-1:0] PAT_RST_EVEN = 16'h0000;
  localparam logic [DW-1:0] PAT_RST_ODD  = 16'h0FFF;
  // field positions
  localparam int PCTL_LANE  = 4;
  localparam int LEN_EN     = 0;
  localparam int MODE_DEMUX = 0;
  localparam int MODE_ALIGN = 1;
  localparam int MODE_DES   = 2;
  localparam int MODE_WID   = 4;
  localparam int PSEL_USR   = 0;
  localparam int CAL_EN     = 0;
  localparam int INV_BASE   = 8;
  // built-in lane sequence, bit i set means sample i is all ones
  localparam logic [NPAT-1:0] LANE_SEQ = 8'hE2;
  localparam logic [3:0][SW-1:0] WID_MASK = {12'hFF0, 12'hFFC, 12'hFFE, 12'hFFF};
  localparam logic [7:0] FRAME_LAST = 8'h7F;
  localparam logic [2:0] PIDX_ONE   = 3'h1;
  localparam logic [2:0] PIDX_TWO   = 3'h2;
  // host apb map
  localparam logic [11:0] H_ADDR  = 12'h000;
  localparam logic [11:0] H_WDATA = 12'h004;
  localparam logic [11:0] H_GO    = 12'h008;
  localparam logic [11:0] H_STAT  = 12'h00C;
  localparam logic [11:0] H_CAP0  = 12'h010;
  localparam logic [11:0] H_CAP1  = 12'h014;
  localparam logic [11:0] H_STRB  = 12'h018;
  localparam int GO_WR = 0;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_REQ  = 3'b010,
    HS_DROP = 3'b100
  } pol_hst_t;
endpackage : pol_pkg

// ==== pol_sva.sv ====
// concurrent checks on the link between output device and host
`timescale 1ns/1ps
module pol_sva (
  input wire logic                                    i_clk,
  input wire logic                                    i_rst_n,
  input wire logic                                    cfg_req,
  input wire logic                                    cfg_we,
  input wire logic [pol_pkg::AW-1:0]                  cfg_addr,
  input wire logic [pol_pkg::DW-1:0]                  cfg_wdata,
  input wire logic                                    cfg_ack,
  input wire logic                                    lclk,
  input wire logic [pol_pkg::NBUS-1:0][pol_pkg::SW-1:0] bus,
  input wire logic                                    strobe,
  input wire logic                                    pwr
);
  import pol_pkg::*;
  logic [7:0] pctl_q, psel_q, mode_q, stb_n_q;
  logic [1:0] falls_q;
  logic       lclk_q, ack_q;
  logic [3:0] ok;
  // shadow of what the device accepted, taken from the handshake itself
  wire logic          wr = cfg_ack && !ack_q && cfg_we;
  wire logic [SW-1:0] wm = WID_MASK[mode_q[MODE_WID +: 2]];
  wire logic          lane_on = psel_q[PSEL_USR] && pctl_q[PCTL_LANE];
  for (genvar i = 0; i < NBUS; i++) begin : g_lane
    wire logic [SW-1:0] x = bus[i] ^ (pctl_q[i] ? (12'h100 << i) : 12'h000);
    assign ok[i] = x == 12'h000 || x == wm || (i > 1 && !mode_q[MODE_DEMUX]);
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pctl_q <= PCTL_RST;
      psel_q <= PSEL_RST;
      mode_q <= OUTPUT_LINK_MODE_RST;
    end else if (wr) begin
      if (cfg_addr == ADR_PCTL) pctl_q <= cfg_wdata[7:0];
      if (cfg_addr == ADR_PSEL) psel_q <= cfg_wdata[7:0];
      if (cfg_addr == ADR_OUTPUT_LINK_MODE) mode_q <= cfg_wdata[7:0];
    end
  end
  // buses only settle two link falls after enable
  always_ff @(posedge i_clk) begin
    lclk_q  <= lclk;
    ack_q   <= cfg_ack;
    stb_n_q <= strobe ? stb_n_q + 8'h01 : 8'h00;
    if (!pwr) falls_q <= 2'h0;
    else if (lclk_q && !lclk && falls_q != 2'h2) falls_q <= falls_q + 2'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_en_rst;
    $rose(i_rst_n) |-> ##[0:3] pwr;
  endproperty
  a_en_rst: assert property (p_en_rst) else $error("link off after reset");
  property p_off_clk;
    (!pwr)[*3] |-> !lclk;
  endproperty
  a_off_clk: assert property (p_off_clk) else $error("link clock runs while off");
  property p_off_bus;
    (!pwr)[*3] |-> bus == '0;
  endproperty
  a_off_bus: assert property (p_off_bus) else $error("buses driven while off");
  property p_off_stb;
    (!pwr)[*3] |-> !strobe;
  endproperty
  a_off_stb: assert property (p_off_stb) else $error("frame strobe while off");
  property p_lclk_hi;
    $rose(lclk) |-> (lclk || !pwr)[*8] ##1 !lclk;
  endproperty
  a_lclk_hi: assert property (p_lclk_hi) else $error("link clock high phase wrong");
  property p_ack;
    $rose(cfg_req) |-> ##[2:8] cfg_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("config request not acknowledged");
  property p_width;
    pwr |-> ((bus[0] | bus[1] | bus[2] | bus[3]) & ~wm) == 12'h000;
  endproperty
  a_width: assert property (p_width) else $error("bits below sample width set");
  property p_lane;
    lclk && pwr && falls_q == 2'h2 && lane_on |-> &ok;
  endproperty
  a_lane: assert property (p_lane) else $error("fixed lane pattern wrong");
  property p_ui;
    $fell(strobe) && pwr |-> stb_n_q == (mode_q[MODE_DEMUX] ? 8'h20 : 8'h10);
  endproperty
  a_ui: assert property (p_ui) else $error("unit interval length wrong");
endmodule : pol_sva
